// ---- verilog/alu_field_defines.svh ----
/*
 * offsets, field positions, reset values and counts for the sampled signal
 * alu field control block.
 * assumes inclusion by bare name from the design module and the bench.
 */
`ifndef ALU_FIELD_DEFINES_SVH
`define ALU_FIELD_DEFINES_SVH

// register word indexes, byte address is four times the index
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_PROG_PTR 4'h2
`define REG_PROG_DATA 4'h3
`define REG_DATA_PTR 4'h4
`define REG_DATA_DATA 4'h5
`define REG_CONV 4'h6

// instruction word field positions
`define OP_LSB 0
`define SHIFT_LSB 3
`define AKIND_LSB 7
`define AIDX_LSB 10
`define SRC_LSB 14
`define DST_LSB 21

// operand select codes
`define SRC_CONST_HI 3'h4
`define SRC_CONST_LAST 7'h4F
`define SRC_CONV 7'h50
`define DST_CONV 6'h3F
`define CND_SIGN_IDX 4'h8

// sizes and counts
`define DATA_WIDTH 25
`define CONV_WIDTH 9
`define DATA_DEPTH 40
`define PROG_DEPTH 192
`define PROG_LAST 8'hBF
`define EOP_TAIL 2'h3

// reset values
`define LIMIT_RESET 1'h1

`endif

// ---- verilog/alu_field_pkg.sv ----
/*
 * types shared by the alu field control block: alu opcodes and analog
 * field kinds.
 * assumes the defines header is on the include path.
 */
`default_nettype none
package alu_field_pkg;
    typedef enum logic [2:0] {
        abs_accumulate_op = 3'h0,
        absolute_op = 3'h1,
        add_op = 3'h2,
        and_op = 3'h3,
        load_op = 3'h4,
        limit_op = 3'h5,
        sub_op = 3'h6,
        xor_op = 3'h7
    } alu_op_type;

    typedef enum logic [2:0] {
        analog_nop = 3'h0,
        analog_cnd = 3'h1,
        analog_cvt = 3'h2,
        analog_in = 3'h3,
        program_end = 3'h4
    } analog_kind_type;
endpackage
`default_nettype wire

// ---- verilog/source_scaler.sv ----
/*
 * power of two source scaler: code 0 multiplies by four, each step above
 * halves, code 15 divides by 8192 with sign fill.
 * assumes a combinational caller on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module source_scaler #(
    parameter int W = 25
) (
    // operand in
    input wire logic [W-1:0] operand,
    input wire logic [3:0] shift_code,
    // scaled operand, two guard bits on top
    output logic [W+1:0] scaled
);
    // pre-shift left by two, then arithmetic right shift by the code
    always_comb begin
        scaled = $signed({operand, 2'h0}) >>> shift_code;
    end
endmodule
`default_nettype wire

// ---- verilog/sampled_signal_alu_field_control.sv ----
/*
 * sampled signal processor alu field control: program memory, data memory,
 * operand select, scaler, conditional alu, conversion register, input
 * sampling and end-of-program looping, with an avalon-mm slave.
 * assumes a comparator level from outside the clock domain and a bus master
 * on clk.
 */
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "alu_field_defines.svh"

// Summary of operation
// - Source: conversion register, memory, sixteen constants
// - Scale source L02 to R13 before ALU
// - Conditional tests sign or register bit 7..0
// - Tested bit zero alters add and load
// - Abs, and, limit ignore conditional entry
// - Conditional abs-accumulate disables limiting; end/xor re-enable
// - Failed conditional add keeps destination, clears carry
// - Failed conditional load likewise; load never carries
// - Conditional subtract adds when previous carry zero
// - Conditional subtract loads register bit0 with carry
// - Convert step loads bit n from comparator, sets n-1
// - Program end wraps to zero after three more
// - Program end switches overflow limiting on
// - Input entry samples one of four channels
// - Analog no-operation idles analog, ALU still runs
// - Program memory holds locations 0 through 191
// - Subtract adds one's complement with carry in
module sampled_signal_alu_field_control #(
    parameter int W = `DATA_WIDTH,
    parameter int CONV_W = `CONV_WIDTH,
    parameter int DATA_DEPTH = `DATA_DEPTH,
    parameter int PROG_DEPTH = `PROG_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // analog section
    input wire logic comparator_in,
    output logic [1:0] channel_select,
    output logic sample_hold,
    output logic [CONV_W-1:0] dac_value,
    // status
    output logic program_end_pulse,
    output logic overflow
);
    typedef struct packed {
        logic [7:0] pc;
        logic [1:0] tail;
        logic tail_on;
        logic carry;
        logic limit_en;
        logic [CONV_W-1:0] conv;
        logic running;
        logic [1:0] chan;
        logic sample;
        logic ovf;
        logic end_pulse;
        logic waitreq;
        logic [31:0] rdata;
        logic [7:0] pptr;
        logic [5:0] dptr;
        logic cmp_meta;
        logic cmp_sync;
    } state_type;

    localparam logic [W-1:0] NEG_ONE = {1'b1, {(W-1){1'b0}}};
    localparam logic [W-1:0] POS_MAX = {1'b0, {(W-1){1'b1}}};
    localparam logic signed [W+2:0] ONE3 = 1;
    localparam logic [W:0] ONE1 = 1;

    state_type st_ff, n;
    logic [31:0] prog_mem [PROG_DEPTH];
    logic [W-1:0] data_mem [DATA_DEPTH];

    logic [31:0] instr, rmux;
    alu_field_pkg::alu_op_type op;
    alu_field_pkg::analog_kind_type akind;
    logic [3:0] shift, aidx;
    logic [6:0] src;
    logic [5:0] dst;
    logic [W-1:0] src_val, dst_val, res_w, data_wd;
    logic [W+1:0] scaled;
    logic signed [W+2:0] sx, dx, ax, full;
    logic [W:0] csum;
    logic cbit, cnd_on, fits, req, done, wr_ok, ctrl_wr;
    logic prog_we, data_we;
    logic [5:0] data_wa;

    // signed eighths: codes 0..7 zero to seven eighths, 8..15 minus one to eight eighths
    function automatic logic [W-1:0] const_value(input logic [3:0] k);
        logic [W-1:0] m;
        m = W'(k[2:0]) + (k[3] ? W'(1) : W'(0));
        m = m << (W - 4);
        return k[3] ? (~m + W'(1)) : m;
    endfunction

    // instruction field decode
    always_comb begin
        instr = prog_mem[st_ff.pc];
        op = alu_field_pkg::alu_op_type'(instr[`OP_LSB +: 3]);
        shift = instr[`SHIFT_LSB +: 4];
        akind = alu_field_pkg::analog_kind_type'(instr[`AKIND_LSB +: 3]);
        aidx = instr[`AIDX_LSB +: 4];
        src = instr[`SRC_LSB +: 7];
        dst = instr[`DST_LSB +: 6];
    end

    // operand fetch
    always_comb begin
        src_val = '0;
        if (src < DATA_DEPTH) begin
            src_val = data_mem[src[5:0]];
        end else if (src[6:4] == `SRC_CONST_HI) begin
            src_val = const_value(src[3:0]);
        end else if (src == `SRC_CONV) begin
            src_val = {st_ff.conv, {(W-CONV_W){1'b0}}};
        end
        dst_val = '0;
        if (dst < DATA_DEPTH) begin
            dst_val = data_mem[dst];
        end else if (dst == `DST_CONV) begin
            dst_val = {st_ff.conv, {(W-CONV_W){1'b0}}};
        end
    end

    source_scaler #(.W(W)) scaler (
        .operand(src_val),
        .shift_code(shift),
        .scaled(scaled)
    );

    // alu with conditional forms and overflow limiting
    always_comb begin
        sx = {scaled[W+1], scaled};
        dx = {{3{dst_val[W-1]}}, dst_val};
        ax = sx[W+2] ? -sx : sx;
        cbit = aidx[3] ? st_ff.conv[CONV_W-1] : st_ff.conv[aidx[2:0]];
        cnd_on = (akind == alu_field_pkg::analog_cnd);
        full = dx;
        csum = {1'b0, dst_val};
        case (op)
            alu_field_pkg::abs_accumulate_op: begin
                full = dx + ax;
                csum = {1'b0, dst_val} + {1'b0, ax[W-1:0]};
            end
            alu_field_pkg::absolute_op: full = ax;
            alu_field_pkg::add_op: begin
                if (!cnd_on || cbit) begin
                    full = dx + sx;
                    csum = {1'b0, dst_val} + {1'b0, sx[W-1:0]};
                end
            end
            alu_field_pkg::and_op: full = dx & sx;
            alu_field_pkg::load_op: begin
                if (!cnd_on || cbit) begin
                    full = sx;
                end
            end
            alu_field_pkg::limit_op: begin
                full = sx[W+2] ? {{3{1'b1}}, NEG_ONE} : {3'h0, POS_MAX};
            end
            alu_field_pkg::sub_op: begin
                if (cnd_on && !st_ff.carry) begin
                    full = dx + sx;
                    csum = {1'b0, dst_val} + {1'b0, sx[W-1:0]};
                end else begin
                    full = dx + ~sx + ONE3;
                    csum = {1'b0, dst_val} + {1'b0, ~sx[W-1:0]} + ONE1;
                end
            end
            default: full = dx ^ sx;
        endcase
        fits = (&full[W+2:W-1]) | ~(|full[W+2:W-1]);
        res_w = full[W-1:0];
        if (!fits && st_ff.limit_en) begin
            res_w = full[W+2] ? NEG_ONE : POS_MAX;
        end
    end

    // bus decode
    always_comb begin
        req = read | write;
        done = req && !st_ff.waitreq;
        wr_ok = done && write && (byteenable == 4'hF);
        ctrl_wr = wr_ok && (address == `REG_CTRL);
        rmux = 32'h0000_0000;
        if (address == `REG_CTRL) begin
            rmux = {31'h0, st_ff.running};
        end else if (address == `REG_STATUS) begin
            rmux = {16'h0000, st_ff.pc, 4'h0, st_ff.ovf, st_ff.limit_en, st_ff.carry, st_ff.running};
        end else if (address == `REG_PROG_PTR) begin
            rmux = {24'h00_0000, st_ff.pptr};
        end else if (address == `REG_PROG_DATA) begin
            rmux = (st_ff.pptr <= `PROG_LAST) ? prog_mem[st_ff.pptr] : 32'h0000_0000;
        end else if (address == `REG_DATA_PTR) begin
            rmux = {26'h0, st_ff.dptr};
        end else if (address == `REG_DATA_DATA) begin
            rmux = (st_ff.dptr < DATA_DEPTH) ? {{(32-W){1'b0}}, data_mem[st_ff.dptr]} : 32'h0000_0000;
        end else if (address == `REG_CONV) begin
            rmux = {{(32-CONV_W){1'b0}}, st_ff.conv};
        end
    end

    // memory write ports: core while running, bus while stopped
    always_comb begin
        prog_we = wr_ok && (address == `REG_PROG_DATA) && !st_ff.running && (st_ff.pptr <= `PROG_LAST);
        data_we = st_ff.running ? (dst < DATA_DEPTH)
                                : (wr_ok && (address == `REG_DATA_DATA) && (st_ff.dptr < DATA_DEPTH));
        data_wa = st_ff.running ? dst : st_ff.dptr;
        data_wd = st_ff.running ? res_w : writedata[W-1:0];
    end

    always_ff @(posedge clk) begin
        if (prog_we) begin
            prog_mem[st_ff.pptr] <= writedata;
        end
        if (data_we) begin
            data_mem[data_wa] <= data_wd;
        end
    end

    // next state
    always_comb begin
        n = st_ff;
        n.waitreq = !(req && st_ff.waitreq);
        n.cmp_meta = comparator_in;
        n.cmp_sync = st_ff.cmp_meta;
        n.sample = 1'b0;
        n.end_pulse = 1'b0;
        if (req && st_ff.waitreq && read) begin
            n.rdata = rmux;
        end
        if (st_ff.running) begin
            n.ovf = !fits;
            n.carry = csum[W];
            if (dst == `DST_CONV) begin
                n.conv = res_w[W-1 -: CONV_W];
            end
            if (op == alu_field_pkg::sub_op && cnd_on) begin
                n.conv[0] = csum[W];
            end
            if (op == alu_field_pkg::abs_accumulate_op && cnd_on) begin
                n.limit_en = 1'b0;
            end
            if (op == alu_field_pkg::xor_op && cnd_on) begin
                n.limit_en = 1'b1;
            end
            // analog section; nop leaves it idle
            case (akind)
                alu_field_pkg::analog_cvt: begin
                    for (int i = 0; i < CONV_W; i++) begin
                        if (i == (aidx[3] ? CONV_W - 1 : int'(aidx[2:0]))) begin
                            n.conv[i] = st_ff.cmp_sync;
                        end else if (i + 1 == (aidx[3] ? CONV_W - 1 : int'(aidx[2:0]))) begin
                            n.conv[i] = 1'b1;
                        end
                    end
                end
                alu_field_pkg::analog_in: begin
                    n.chan = aidx[1:0];
                    n.sample = 1'b1;
                end
                alu_field_pkg::program_end: begin
                    n.limit_en = 1'b1;
                    n.end_pulse = 1'b1;
                end
                default: n.sample = 1'b0;
            endcase
            // sequencing: three more instructions run after program end
            if (st_ff.tail_on && st_ff.tail == 2'h1) begin
                n.pc = 8'h00;
                n.tail_on = 1'b0;
            end else begin
                n.pc = (st_ff.pc == `PROG_LAST) ? 8'h00 : st_ff.pc + 8'h01;
                if (st_ff.tail_on) begin
                    n.tail = st_ff.tail - 2'h1;
                end else if (akind == alu_field_pkg::program_end) begin
                    n.tail_on = 1'b1;
                    n.tail = `EOP_TAIL;
                end
            end
        end
        // bus effects last so a start overrides sequencing
        if (ctrl_wr) begin
            n.running = writedata[0];
            if (writedata[0]) begin
                n.pc = 8'h00;
                n.tail_on = 1'b0;
            end
        end
        if (wr_ok && address == `REG_PROG_PTR) begin
            n.pptr = writedata[7:0];
        end
        if (wr_ok && address == `REG_DATA_PTR) begin
            n.dptr = writedata[5:0];
        end
        if (wr_ok && address == `REG_CONV && !st_ff.running) begin
            n.conv = writedata[CONV_W-1:0];
        end
        if (done && address == `REG_PROG_DATA && (read || (wr_ok && !st_ff.running))) begin
            n.pptr = st_ff.pptr + 8'h01;
        end
        if (done && address == `REG_DATA_DATA && (read || (wr_ok && !st_ff.running))) begin
            n.dptr = st_ff.dptr + 6'h01;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.limit_en <= `LIMIT_RESET;
            st_ff.waitreq <= 1'b1;
        end else begin
            st_ff <= n;
        end
    end

    // outputs straight from the state register
    always_comb begin
        readdata = st_ff.rdata;
        waitrequest = st_ff.waitreq;
        channel_select = st_ff.chan;
        sample_hold = st_ff.sample;
        dac_value = st_ff.conv;
        program_end_pulse = st_ff.end_pulse;
        overflow = st_ff.ovf;
    end

    // checks
    logic run_ok;
    assign run_ok = st_ff.running && !ctrl_wr;

    sequence s_run3;
        run_ok [*3];
    endsequence

    property p_const_last;
        @(posedge clk) disable iff (!resetn)
        (src == `SRC_CONST_LAST) |-> (src_val == NEG_ONE);
    endproperty
    a_const_last: assert property (p_const_last) else $error("minus one constant wrong");

    property p_scale_l02;
        @(posedge clk) disable iff (!resetn)
        (shift == 4'h0) |-> (scaled == {src_val, 2'h0});
    endproperty
    a_scale_l02: assert property (p_scale_l02) else $error("left shift by two wrong");

    property p_cnd_add;
        @(posedge clk) disable iff (!resetn)
        (st_ff.running && op == alu_field_pkg::add_op && cnd_on && !cbit)
            |-> (res_w == dst_val) ##1 !st_ff.carry;
    endproperty
    a_cnd_add: assert property (p_cnd_add) else $error("failed conditional add changed state");

    property p_load_carry;
        @(posedge clk) disable iff (!resetn)
        (st_ff.running && op == alu_field_pkg::load_op) |=> !st_ff.carry;
    endproperty
    a_load_carry: assert property (p_load_carry) else $error("load produced carry");

    property p_sub_sel;
        @(posedge clk) disable iff (!resetn)
        (st_ff.running && op == alu_field_pkg::sub_op)
            |-> (full == ((st_ff.carry || !cnd_on) ? dx - sx : dx + sx));
    endproperty
    a_sub_sel: assert property (p_sub_sel) else $error("subtract direction wrong");

    property p_bit0_carry;
        @(posedge clk) disable iff (!resetn)
        (st_ff.running && op == alu_field_pkg::sub_op && cnd_on) |=> (st_ff.conv[0] == $past(csum[W]));
    endproperty
    a_bit0_carry: assert property (p_bit0_carry) else $error("bit zero not loaded with carry");

    property p_cvt7;
        @(posedge clk) disable iff (!resetn)
        (st_ff.running && akind == alu_field_pkg::analog_cvt && aidx == 4'h7)
            |=> (st_ff.conv[7] == $past(st_ff.cmp_sync)) && st_ff.conv[6];
    endproperty
    a_cvt7: assert property (p_cvt7) else $error("convert step bits wrong");

    property p_eop_wrap;
        @(posedge clk) disable iff (!resetn)
        (run_ok && akind == alu_field_pkg::program_end && !st_ff.tail_on) ##1 s_run3
            |=> (st_ff.pc == 8'h00);
    endproperty
    a_eop_wrap: assert property (p_eop_wrap) else $error("no wrap after three more");

    property p_limit_on;
        @(posedge clk) disable iff (!resetn)
        (st_ff.running && akind == alu_field_pkg::program_end) |=> st_ff.limit_en;
    endproperty
    a_limit_on: assert property (p_limit_on) else $error("limiting not enabled");

    property p_aba_off;
        @(posedge clk) disable iff (!resetn)
        (st_ff.running && op == alu_field_pkg::abs_accumulate_op && cnd_on) |=> !st_ff.limit_en;
    endproperty
    a_aba_off: assert property (p_aba_off) else $error("limiting not disabled");

    property p_input;
        @(posedge clk) disable iff (!resetn)
        (st_ff.running && akind == alu_field_pkg::analog_in)
            |=> st_ff.sample && (st_ff.chan == $past(aidx[1:0]));
    endproperty
    a_input: assert property (p_input) else $error("input channel not sampled");

    property p_pc_range;
        @(posedge clk) disable iff (!resetn)
        st_ff.pc <= `PROG_LAST;
    endproperty
    a_pc_range: assert property (p_pc_range) else $error("program counter past last location");
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
/*
 * self-checking bench for the alu field control block: loads two programs over
 * avalon-mm, runs them, reads results back and watches the analog pulses.
 * assumes the defines header on the include path and the package compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "alu_field_defines.svh"
module tb;
    localparam logic [2:0] ld = alu_field_pkg::load_op;
    localparam logic [2:0] ad = alu_field_pkg::add_op;
    localparam logic [2:0] sb = alu_field_pkg::sub_op;
    localparam logic [2:0] ab = alu_field_pkg::absolute_op;
    localparam logic [2:0] aa = alu_field_pkg::abs_accumulate_op;
    localparam logic [2:0] xr = alu_field_pkg::xor_op;
    localparam logic [2:0] an_nop = alu_field_pkg::analog_nop;
    localparam logic [2:0] an_cnd = alu_field_pkg::analog_cnd;
    localparam logic [2:0] an_cvt = alu_field_pkg::analog_cvt;
    localparam logic [2:0] an_in = alu_field_pkg::analog_in;
    localparam logic [2:0] an_end = alu_field_pkg::program_end;
    // bench signals
    logic clk, resetn, read, write, comparator_in, waitrequest, sample_hold, program_end_pulse, overflow;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata;
    logic [1:0] channel_select, exp_chan;
    logic [8:0] dac_value;
    int n_mismatch = 0;
    int cmp_count = 0;
    int n_ovf = 0;
    int n_end = 0;
    int gap = 1000;
    int exp_period = 0;
    int r;
    integer seed = 32'h5d4c_3cbf;
    logic [63:0] notes [$];
    logic [31:0] prog [32];
    logic [24:0] dexp [8];

    sampled_signal_alu_field_control dut (.clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .comparator_in(comparator_in), .channel_select(channel_select),
        .sample_hold(sample_hold), .dac_value(dac_value), .program_end_pulse(program_end_pulse),
        .overflow(overflow));

    // 100 mhz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // watchdog, about ten times the expected run of some 300 cycles
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    task automatic wrap_up();
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    // instruction word builder
    function automatic logic [31:0] ins(input logic [2:0] op, input logic [3:0] sh, input logic [2:0] ak,
        input logic [3:0] ai, input logic [6:0] src, input logic [5:0] dst);
        ins = {5'h0, dst, src, ai, ak, sh, op};
    endfunction

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= ~wr;
        writedata <= d;
        byteenable <= be;
        // only the watchdog ends a wait that never comes
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    // note the expected word, then read
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back({m, e});
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask

    task automatic load(input int n);
        wr(`REG_PROG_PTR, 32'h0000_0000);
        for (int i = 0; i < n; i++) wr(`REG_PROG_DATA, prog[i]);
    endtask

    // output watcher: read answers, input samples, program end spacing
    always @(posedge clk) begin
        logic [63:0] nt;
        if (read && waitrequest === 1'b0 && notes.size() > 0) begin
            nt = notes.pop_front();
            check("readdata", nt[31:0], readdata & nt[63:32]);
        end
        if (sample_hold === 1'b1) check("channel_select", {30'h0, exp_chan}, {30'h0, channel_select});
        if (overflow === 1'b1) n_ovf++;
        gap = gap + 1;
        if (program_end_pulse === 1'b1) begin
            n_end++;
            if (gap < 100) check("program_end period", exp_period, gap);
            gap = 0;
        end
    end

    // main sequence
    initial begin
        resetn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        byteenable = 4'hF;
        writedata = 32'h0000_0000;
        comparator_in = 1'b0;
        exp_chan = 2'h2;
        dexp = '{25'h0E0_0000, 25'h1FF_F800, 25'h040_0000, 25'h020_0000, 25'h040_0000, 25'h080_0000,
            25'h0FF_FFFF, 25'h180_0000};
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(`REG_STATUS, 32'h0000_0004, 32'h0000_00FF);
        rd(4'hB, 32'h0000_0000, 32'hFFFF_FFFF);
        // arithmetic program, stopped inside its filler tail
        for (int i = 0; i < 32; i++) prog[i] = ins(ld, 4'h2, an_nop, 4'h0, 7'h40, 6'h3E);
        prog[0] = ins(ld, 4'h2, an_nop, 4'h0, 7'h43, 6'h00);
        prog[1] = ins(ld, 4'hF, an_nop, 4'h0, 7'h4F, 6'h01);
        prog[2] = ins(ad, 4'h0, an_cnd, 4'h5, 7'h41, 6'h00);
        prog[3] = ins(ad, 4'h2, an_cnd, 4'h8, 7'h47, 6'h01);
        prog[4] = ins(ld, 4'h2, an_nop, 4'h0, 7'h42, 6'h02);
        prog[5] = ins(ld, 4'h2, an_cnd, 4'h6, 7'h45, 6'h02);
        prog[6] = ins(ld, 4'h2, an_nop, 4'h0, 7'h44, 6'h03);
        prog[7] = ins(ad, 4'h2, an_nop, 4'h0, 7'h49, 6'h03);
        prog[8] = ins(sb, 4'h2, an_cnd, 4'h3, 7'h41, 6'h03);
        prog[9] = ins(ld, 4'h2, an_nop, 4'h0, 7'h41, 6'h04);
        prog[10] = ins(sb, 4'h2, an_cnd, 4'h3, 7'h41, 6'h04);
        prog[11] = ins(ab, 4'h2, an_cnd, 4'h6, 7'h4B, 6'h05);
        // saturate with limiting on, wrap with it off, then turn it back on
        prog[12] = ins(ld, 4'h0, an_nop, 4'h0, 7'h43, 6'h06);
        prog[13] = ins(aa, 4'h2, an_cnd, 4'h0, 7'h40, 6'h3E);
        prog[14] = ins(ld, 4'h0, an_nop, 4'h0, 7'h43, 6'h07);
        prog[15] = ins(xr, 4'h2, an_cnd, 4'h0, 7'h40, 6'h3E);
        prog[28] = ins(ld, 4'h2, an_end, 4'h0, 7'h40, 6'h3E);
        load(32);
        rd(`REG_PROG_PTR, 32'h0000_0020, 32'hFFFF_FFFF);
        wr(`REG_CONV, 32'h0000_0021);
        wr(`REG_CTRL, 32'h0000_0001);
        repeat (22) @(posedge clk);
        wr(`REG_CTRL, 32'h0000_0000);
        wr(`REG_DATA_PTR, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            rd(`REG_DATA_DATA, {7'h0, dexp[i]}, 32'h01FF_FFFF);
        end
        rd(`REG_CONV, 32'h0000_0020, 32'h0000_01FF);
        check("dac_value", 32'h0000_0020, {23'h0, dac_value});
        check("overflow count", 32'h0000_0002, n_ovf);
        rd(`REG_STATUS, 32'h0000_0004, 32'h0000_000F);
        // partial byte enables leave the pointer alone
        bus(1'b1, `REG_PROG_PTR, 32'h0000_0055, 4'h3);
        rd(`REG_PROG_PTR, 32'h0000_0020, 32'hFFFF_FFFF);
        // analog program: sample, two spaced conversion steps, loop of eight
        for (int i = 0; i < 8; i++) prog[i] = ins(ld, 4'h2, an_nop, 4'h0, 7'h40, 6'h3E);
        prog[0] = ins(ld, 4'h2, an_in, 4'h2, 7'h40, 6'h3E);
        prog[1] = ins(ld, 4'h2, an_in, 4'h2, 7'h40, 6'h3E);
        prog[2] = ins(ld, 4'h2, an_cvt, 4'h7, 7'h40, 6'h3E);
        prog[4] = ins(ld, 4'h2, an_end, 4'h0, 7'h40, 6'h3E);
        prog[5] = ins(ld, 4'h2, an_cvt, 4'h3, 7'h40, 6'h3E);
        load(8);
        r = $random(seed);
        comparator_in <= r[0];
        exp_period = 8;
        wr(`REG_CONV, 32'h0000_0000);
        wr(`REG_CTRL, 32'h0000_0001);
        repeat (40) @(posedge clk);
        wr(`REG_CTRL, 32'h0000_0000);
        rd(`REG_CONV, r[0] ? 32'h0000_00CC : 32'h0000_0044, 32'h0000_01FF);
        check("dac_value", r[0] ? 32'h0000_00CC : 32'h0000_0044, {23'h0, dac_value});
        check("program_end count", 32'h0000_0005, n_end);
        // let the watcher take the last read answer first
        repeat (2) @(posedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
